// File: verilog/rtcm_defs.vh
`ifndef RTCM_DEFS_VH
`define RTCM_DEFS_VH
// slave address and direction codes
`define RTCM_SLAVE_ADDR 7'h68
`define RTCM_DIR_WRITE 1'b0
`define RTCM_DIR_READ 1'b1
// pointer space: last ram location, wraps to first clock location
`define RTCM_PTR_LAST 8'h3F
`define RTCM_PTR_FIRST 8'h00
// timing: standard mode, at most 100 kHz
`define RTCM_CLK_HZ 125000000
`define RTCM_SCL_KHZ 100
// quarter of an scl period in system cycles, rounded up so the rate stays at or below 100 kHz
`define RTCM_QUARTER_CYC ((`RTCM_CLK_HZ + 4 * 1000 * `RTCM_SCL_KHZ - 1) / (4 * 1000 * `RTCM_SCL_KHZ))
`define RTCM_QCNT_W 9
// bits per byte
`define RTCM_BYTE_BITS 4'd8
`endif

// File: verilog/rtcm_buf2.v
// two-entry skid buffer: the read path keeps up to two words while the user stalls
module rtcm_buf2 (
    // clock and control
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    // fill side
    input wire i_valid,
    output wire o_ready,
    input wire [7:0] i_data,
    // drain side
    output wire o_valid,
    input wire i_ready,
    output wire [7:0] o_data
);
    reg [7:0] mem_q [0:1];
    reg wr_q;
    reg rd_q;
    reg [1:0] cnt_q;
    wire push;
    wire pop;

    assign o_ready = (cnt_q != 2'd2);
    assign o_valid = (cnt_q != 2'd0);
    assign o_data = mem_q[rd_q];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'd0;
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
        end
        else if (i_ce)
        begin
            if (push)
            begin
                mem_q[wr_q] <= i_data;
                wr_q <= ~wr_q;
            end
            if (pop)
                rd_q <= ~rd_q;
            if (push && !pop)
                cnt_q <= cnt_q + 2'd1;
            else if (pop && !push)
                cnt_q <= cnt_q - 2'd1;
        end
    end
endmodule

// File: verilog/rtcm_master.v
`include "rtcm_defs.vh"

// How it works
// - we master; we make scl, start, stop
// - start: sda falls while scl high
// - stop: sda rises while scl high
// - sda changes only while scl low
// - start only after both lines seen high
// - eight bits then ninth acknowledge bit
// - scl no faster than 100 kHz
// - acknowledge held low through scl high
// - bytes shifted most significant bit first
// - burst length chosen by us, unbounded; i_cmd_len caps it at 255 data bytes
// - repeated start restarts address phase
// - address 1101000, direction 0 writes
// - direction 1 reads from slave
// - first write byte sets slave pointer
// - we acknowledge all read bytes but last
// - nack ends read, then we stop
module rtcm_master (
    // clock, reset, enable
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    // command: i_cmd_rd selects read; i_cmd_len is data bytes after address/pointer
    input wire i_cmd_valid,
    output wire o_cmd_ready,
    input wire i_cmd_rd,
    input wire i_cmd_ptr_en,
    input wire [7:0] i_cmd_ptr,
    input wire [7:0] i_cmd_len,
    // write data stream
    input wire i_wr_valid,
    output wire o_wr_ready,
    input wire [7:0] i_wr_data,
    // read data stream
    output wire o_rd_valid,
    input wire i_rd_ready,
    output wire [7:0] o_rd_data,
    // status
    output wire o_busy,
    output reg o_nack_q,
    // bus pins, open drain
    input wire i_scl,
    output wire o_scl,
    output wire o_scl_oe,
    input wire i_sda,
    output wire o_sda,
    output wire o_sda_oe
);
    localparam [7:0] S_IDLE = 8'h01;
    localparam [7:0] S_START = 8'h02;
    localparam [7:0] S_BYTE = 8'h04;
    localparam [7:0] S_ACK = 8'h08;
    localparam [7:0] S_LOAD = 8'h10;
    localparam [7:0] S_STOP = 8'h20;
    localparam [7:0] S_WAIT = 8'h40;
    localparam [7:0] S_DONE = 8'h80;
    localparam [1:0] P_ADDR = 2'd0;
    localparam [1:0] P_PTR = 2'd1;
    localparam [1:0] P_WDAT = 2'd2;
    localparam [1:0] P_RDAT = 2'd3;
    localparam integer QCYC = `RTCM_QUARTER_CYC - 1;
    localparam [`RTCM_QCNT_W-1:0] QMAX = QCYC[`RTCM_QCNT_W-1:0];

    reg [7:0] st_q;
    reg [1:0] ph_q;
    reg [1:0] qtr_q;
    reg [`RTCM_QCNT_W-1:0] div_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg [7:0] left_q;
    reg rd_q;
    reg ptr_q;
    reg [7:0] ptrv_q;
    reg restart_q;
    reg sda_drv_q;
    reg scl_drv_q;
    reg ack_q;
    reg [1:0] scl_s_q;
    reg [1:0] sda_s_q;
    reg rd_push_q;
    reg [7:0] rd_dat_q;
    wire tick;
    wire rd_ready;
    wire bus_idle;

    // pins pass two flops; first flop read by nothing else
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            scl_s_q <= 2'b11;
            sda_s_q <= 2'b11;
        end
        else if (i_ce)
        begin
            scl_s_q <= {scl_s_q[0], i_scl};
            sda_s_q <= {sda_s_q[0], i_sda};
        end
    end

    assign bus_idle = scl_s_q[1] && sda_s_q[1];
    // quarter-period tick; scl high phase stretched if a slave holds it low
    assign tick = (div_q == QMAX);
    assign o_scl = 1'b0;
    assign o_scl_oe = scl_drv_q;
    assign o_sda = 1'b0;
    assign o_sda_oe = sda_drv_q;
    assign o_cmd_ready = (st_q == S_IDLE);
    assign o_busy = (st_q != S_IDLE);
    // ready exactly when the load or wait step copies i_wr_data into the shifter
    assign o_wr_ready = tick && !rd_q && ((st_q == S_WAIT) || ((st_q == S_LOAD) && ack_q
        && !(ph_q == P_ADDR && ptr_q && !restart_q)
        && !(ph_q == P_WDAT ? left_q == 8'd1 : left_q == 8'd0)));

    rtcm_buf2 u_rdbuf (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_valid(rd_push_q),
        .o_ready(rd_ready),
        .i_data(rd_dat_q),
        .o_valid(o_rd_valid),
        .i_ready(i_rd_ready),
        .o_data(o_rd_data)
    );

    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            st_q <= S_IDLE;
            ph_q <= P_ADDR;
            qtr_q <= 2'd0;
            div_q <= {`RTCM_QCNT_W{1'b0}};
            bit_q <= 4'd0;
            sh_q <= 8'h00;
            left_q <= 8'h00;
            rd_q <= 1'b0;
            ptr_q <= 1'b0;
            ptrv_q <= 8'h00;
            restart_q <= 1'b0;
            sda_drv_q <= 1'b0;
            scl_drv_q <= 1'b0;
            ack_q <= 1'b0;
            o_nack_q <= 1'b0;
            rd_push_q <= 1'b0;
            rd_dat_q <= 8'h00;
        end
        else if (i_ce)
        begin
            rd_push_q <= 1'b0;
            // 4 quarters of >=2.5 us give a period >=10 us
            if (tick || st_q == S_IDLE)
                div_q <= {`RTCM_QCNT_W{1'b0}};
            else if (!(qtr_q == 2'd2 && !scl_drv_q && !scl_s_q[1]))
                div_q <= div_q + {{(`RTCM_QCNT_W-1){1'b0}}, 1'b1};
            if (tick && st_q != S_IDLE)
                qtr_q <= qtr_q + 2'd1;
            case (st_q)
                S_IDLE:
                begin
                    qtr_q <= 2'd0;
                    if (i_cmd_valid && bus_idle)
                    begin
                        rd_q <= i_cmd_rd;
                        ptr_q <= i_cmd_ptr_en;
                        ptrv_q <= i_cmd_ptr;
                        left_q <= i_cmd_len;
                        restart_q <= 1'b0;
                        o_nack_q <= 1'b0;
                        st_q <= S_START;
                    end
                end
                S_START:
                    // q0 release sda, q1 sda low with scl high, q2 scl low
                    if (tick)
                    begin
                        if (qtr_q == 2'd0)
                        begin
                            sda_drv_q <= 1'b0;
                            scl_drv_q <= 1'b0;
                        end
                        else if (qtr_q == 2'd1)
                            sda_drv_q <= 1'b1;
                        else if (qtr_q == 2'd2)
                        begin
                            scl_drv_q <= 1'b1;
                            ph_q <= P_ADDR;
                            // repeated start after pointer write turns to read
                            sh_q <= {`RTCM_SLAVE_ADDR,
                                (rd_q && !(ptr_q && !restart_q))};
                            bit_q <= 4'd0;
                            qtr_q <= 2'd0;
                            st_q <= S_BYTE;
                        end
                    end
                S_BYTE:
                    // q0 set sda while scl low, q1 scl high, q2 sample, q3 scl low
                    if (tick)
                    begin
                        if (qtr_q == 2'd0)
                            sda_drv_q <= (ph_q == P_RDAT) ? 1'b0 : !sh_q[7];
                        else if (qtr_q == 2'd1)
                            scl_drv_q <= 1'b0;
                        else if (qtr_q == 2'd2)
                        begin
                            if (ph_q == P_RDAT)
                                sh_q <= {sh_q[6:0], sda_s_q[1]};
                            else
                                sh_q <= {sh_q[6:0], 1'b0};
                            bit_q <= bit_q + 4'd1;
                        end
                        else
                        begin
                            scl_drv_q <= 1'b1;
                            if (bit_q == `RTCM_BYTE_BITS)
                                st_q <= S_ACK;
                        end
                    end
                S_ACK:
                    if (tick)
                    begin
                        if (qtr_q == 2'd0)
                        begin
                            // we ack read bytes unless this is the last
                            if (ph_q == P_RDAT)
                                sda_drv_q <= (left_q != 8'd1);
                            else
                                sda_drv_q <= 1'b0;
                        end
                        else if (qtr_q == 2'd1)
                            scl_drv_q <= 1'b0;
                        else if (qtr_q == 2'd2)
                            ack_q <= (ph_q == P_RDAT) ? 1'b1 : !sda_s_q[1];
                        else
                        begin
                            scl_drv_q <= 1'b1;
                            st_q <= S_LOAD;
                        end
                    end
                S_LOAD:
                    // decide next byte at a quarter tick; scl stays low
                    if (tick)
                    begin
                        qtr_q <= 2'd0;
                        bit_q <= 4'd0;
                        if (ph_q == P_RDAT)
                        begin
                            rd_dat_q <= sh_q;
                            rd_push_q <= 1'b1;
                            left_q <= left_q - 8'd1;
                        end
                        else if (ph_q == P_WDAT)
                            left_q <= left_q - 8'd1;
                        if (!ack_q)
                        begin
                            o_nack_q <= 1'b1;
                            st_q <= S_STOP;
                        end
                        else if (ph_q == P_ADDR && ptr_q && !restart_q)
                        begin
                            sh_q <= ptrv_q;
                            ph_q <= P_PTR;
                            st_q <= S_BYTE;
                        end
                        else if (ph_q == P_PTR && rd_q)
                        begin
                            restart_q <= 1'b1;
                            st_q <= S_START;
                        end
                        else if (ph_q == P_RDAT && left_q == 8'd1)
                            st_q <= S_STOP;
                        else if (rd_q)
                        begin
                            ph_q <= P_RDAT;
                            if (left_q == 8'd0 && ph_q != P_RDAT)
                                st_q <= S_STOP;
                            else if (ph_q == P_RDAT && !rd_ready)
                                st_q <= S_WAIT;
                            else
                                st_q <= S_BYTE;
                        end
                        else if ((ph_q == P_WDAT ? left_q == 8'd1 : left_q == 8'd0))
                            st_q <= S_STOP;
                        else if (i_wr_valid)
                        begin
                            sh_q <= i_wr_data;
                            ph_q <= P_WDAT;
                            st_q <= S_BYTE;
                        end
                        else
                        begin
                            // source stalled; hold scl low and retry
                            ph_q <= P_WDAT;
                            st_q <= S_WAIT;
                        end
                    end
                S_WAIT:
                    // buffer full or no write word: scl held low, but the read byte pushed on entry is lost unless a word is popped in that same tick cycle
                    if (tick)
                    begin
                        if (rd_q ? rd_ready : i_wr_valid)
                        begin
                            qtr_q <= 2'd0;
                            if (!rd_q)
                                sh_q <= i_wr_data;
                            st_q <= S_BYTE;
                        end
                    end
                S_STOP:
                    // q0 sda low, q1 scl high, q2 sda rises
                    if (tick)
                    begin
                        if (qtr_q == 2'd0)
                            sda_drv_q <= 1'b1;
                        else if (qtr_q == 2'd1)
                            scl_drv_q <= 1'b0;
                        else if (qtr_q == 2'd2)
                        begin
                            sda_drv_q <= 1'b0;
                            st_q <= S_DONE;
                        end
                    end
                S_DONE:
                    // one bus-free quarter before accepting the next command
                    if (tick)
                        st_q <= S_IDLE;
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end
endmodule

// File: verif/rtcm_master_chk.sv
module rtcm_master_chk (
    // clock and reset
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    // command and streams
    input wire i_cmd_valid,
    input wire o_cmd_ready,
    input wire o_busy,
    input wire o_nack_q,
    input wire o_wr_ready,
    input wire o_rd_valid,
    input wire i_rd_ready,
    input wire [7:0] o_rd_data,
    // bus pins
    input wire i_scl,
    input wire i_sda,
    input wire o_scl_oe,
    input wire o_sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic [8:0] phase_q;
    // saturates so a long idle cannot wrap into a false short phase
    always @(posedge i_clk)
    begin
        if (i_sys_rst || $changed(o_scl_oe))
            phase_q <= 9'h000;
        else if (phase_q != 9'h1FF)
            phase_q <= phase_q + 9'h001;
    end
    ready_idle_a: assert property (o_cmd_ready == !o_busy)
        else $error("command ready disagrees with busy");
    cmd_take_a: assert property ((i_ce && i_cmd_valid && o_cmd_ready && i_scl && i_sda)[*4] |=> o_busy)
        else $error("command not taken on idle bus");
    start_idle_a: assert property ($rose(o_busy) |-> !o_sda_oe && !o_scl_oe)
        else $error("bus not released when transfer begins");
    start_first_a: assert property ($rose(o_busy) |-> !o_scl_oe throughout ##[0:1000] $rose(o_sda_oe))
        else $error("no start with clock high");
    scl_rate_a: assert property ($changed(o_scl_oe) |-> phase_q >= 9'd312)
        else $error("clock phase shorter than a quarter");
    sda_rise_a: assert property ($fell(o_scl_oe) |-> $stable(o_sda_oe)[*8])
        else $error("data moved around clock rise");
    stop_done_a: assert property ($fell(o_sda_oe) && !o_scl_oe && !$past(o_scl_oe) |-> ##[1:1000] !o_busy)
        else $error("stop did not end the transfer");
    nack_stop_a: assert property ($rose(o_nack_q) |-> o_busy && !o_rd_valid)
        else $error("refusal flag raised outside transfer");
    wr_busy_a: assert property (o_wr_ready |-> o_busy)
        else $error("write word taken while idle");
    rd_hold_a: assert property (o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_data))
        else $error("read word lost under stall");
endmodule

bind rtcm_master rtcm_master_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
    .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready), .o_busy(o_busy), .o_nack_q(o_nack_q),
    .o_wr_ready(o_wr_ready), .o_rd_valid(o_rd_valid), .i_rd_ready(i_rd_ready),
    .o_rd_data(o_rd_data), .i_scl(i_scl), .i_sda(i_sda), .o_scl_oe(o_scl_oe),
    .o_sda_oe(o_sda_oe));

// File: verif/rtcm_dev_model.sv
module rtcm_dev_model (
    // sampling clock and pins
    input wire logic i_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    // refuse the address when high
    input wire logic i_absent,
    output logic o_sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:63];
    logic [7:0] sh_q, tx_q;
    logic [5:0] ptr_q;
    logic [3:0] cnt_q;
    logic [1:0] ph_q;
    logic act_q, first_q, s1_q, d1_q;
    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i] = 8'(i) ^ 8'hA5;
        ptr_q = 6'h00;
        act_q = 1'b0;
        o_sda_oe = 1'b0;
        s1_q = 1'b1;
        d1_q = 1'b1;
    end
    // pins sampled once per clock; sda moving while scl is high in both samples marks a start or a stop
    always @(posedge i_clk)
    begin
        s1_q <= i_scl;
        d1_q <= i_sda;
        if (s1_q && i_scl && d1_q && !i_sda)
        begin
            act_q <= 1'b1;
            ph_q <= 2'd0;
            // the start's own scl fall wraps this to 0 before the first bit
            cnt_q <= 4'hF;
            o_sda_oe <= 1'b0;
        end
        else if (s1_q && i_scl && !d1_q && i_sda)
        begin
            act_q <= 1'b0;
            o_sda_oe <= 1'b0;
        end
        else if (act_q && !s1_q && i_scl)
        begin
            if (cnt_q < 4'd8)
                sh_q <= {sh_q[6:0], i_sda};
            else if (ph_q == 2'd2 && i_sda)
                act_q <= 1'b0;
        end
        else if (act_q && s1_q && !i_scl)
        begin
            cnt_q <= (cnt_q == 4'd8) ? 4'd0 : cnt_q + 4'd1;
            if (cnt_q == 4'd7 && ph_q == 2'd2)
                o_sda_oe <= 1'b0;
            else if (cnt_q == 4'd7 && ph_q == 2'd0)
            begin
                if (sh_q[7:1] == 7'h68 && !i_absent)
                begin
                    o_sda_oe <= 1'b1;
                    ph_q <= sh_q[0] ? 2'd2 : 2'd1;
                    first_q <= 1'b1;
                end
                else
                    act_q <= 1'b0;
            end
            else if (cnt_q == 4'd7)
            begin
                o_sda_oe <= 1'b1;
                first_q <= 1'b0;
                if (first_q)
                    ptr_q <= sh_q[5:0];
                else
                begin
                    mem[ptr_q] <= sh_q;
                    ptr_q <= ptr_q + 6'h01;
                end
            end
            else if (cnt_q == 4'd8)
            begin
                o_sda_oe <= (ph_q == 2'd2) ? !mem[ptr_q][7] : 1'b0;
                if (ph_q == 2'd2)
                begin
                    tx_q <= mem[ptr_q] << 1;
                    ptr_q <= ptr_q + 6'h01;
                end
            end
            else if (ph_q == 2'd2)
            begin
                o_sda_oe <= !tx_q[7];
                tx_q <= tx_q << 1;
            end
        end
    end
endmodule

// File: verif/test_rtcm_master.sv
module test_rtcm_master;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_sys_rst, cmd_valid, cmd_rd, cmd_ptr_en, wr_valid, rd_ready, absent, stall;
    logic [7:0] cmd_ptr, cmd_len, wr_data, d0;
    wire cmd_ready, wr_ready, rd_valid, busy, nack, scl_oe, sda_oe, dev_oe;
    wire [7:0] rd_data;
    wire scl_w = !scl_oe;
    wire sda_w = !(sda_oe || dev_oe);
    int error_cnt, checks_done, seed;
    logic [7:0] got [$];
    rtcm_master dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1), .i_cmd_valid(cmd_valid),
        .o_cmd_ready(cmd_ready), .i_cmd_rd(cmd_rd), .i_cmd_ptr_en(cmd_ptr_en),
        .i_cmd_ptr(cmd_ptr), .i_cmd_len(cmd_len), .i_wr_valid(wr_valid), .o_wr_ready(wr_ready),
        .i_wr_data(wr_data), .o_rd_valid(rd_valid), .i_rd_ready(rd_ready), .o_rd_data(rd_data),
        .o_busy(busy), .o_nack_q(nack), .i_scl(scl_w), .o_scl(), .o_scl_oe(scl_oe),
        .i_sda(sda_w), .o_sda(), .o_sda_oe(sda_oe));
    rtcm_dev_model u_dev (.i_clk(i_clk), .i_scl(scl_w), .i_sda(sda_w), .i_absent(absent),
        .o_sda_oe(dev_oe));
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = !i_clk;
    end
    function automatic logic [7:0] init_val(input int i);
        return 8'(i) ^ 8'hA5;
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_for(input string name, input logic want, input int bound);
        int n;
        n = 0;
        while (!((name == "busy" ? busy : (name == "ready" ? cmd_ready : rd_valid)) === want))
        begin
            @(posedge i_clk);
            #1;
            n++;
            if (n > bound)
            begin
                check(name, 8'(!want), 8'(want));
                stop_test();
            end
        end
    endtask
    task automatic run_cmd(input logic rd, input logic pe, input logic [7:0] p, input logic [7:0] l);
        @(posedge i_clk);
        cmd_rd <= rd;
        cmd_ptr_en <= pe;
        cmd_ptr <= p;
        cmd_len <= l;
        cmd_valid <= 1'b1;
        wait_for("busy", 1'b1, 100);
        @(posedge i_clk);
        cmd_valid <= 1'b0;
        check("busy", 8'(busy), 8'h01);
        wait_for("busy", 1'b0, 80000);
    endtask
    // a stall lets the two-entry read buffer fill while the bus keeps running
    always @(posedge i_clk)
    begin
        rd_ready <= stall ? 1'b0 : 1'($random(seed));
        if (rd_valid && rd_ready)
            got.push_back(rd_data);
        if (wr_valid && wr_ready)
            wr_valid <= 1'b0;
    end
    initial
    begin
        seed = 95757;
        {cmd_valid, cmd_rd, cmd_ptr_en, wr_valid, absent} = 5'h00;
        {cmd_ptr, cmd_len, wr_data} = 24'h000000;
        stall = 1'b0;
        i_sys_rst = 1'b1;
        repeat (12) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        check("idle", {busy, cmd_ready, rd_valid, nack, scl_oe, sda_oe}, 8'h10);
        d0 = 8'($random(seed));
        wr_data <= d0;
        wr_valid <= 1'b1;
        run_cmd(1'b0, 1'b1, 8'h3F, 8'h01);
        check("ram_3f", u_dev.mem[63], d0);
        check("ptr_wrap", {2'b00, u_dev.ptr_q}, 8'h00);
        check("ack_w", 8'(nack), 8'h00);
        check("wr_taken", 8'(wr_valid), 8'h00);
        stall = 1'b1;
        run_cmd(1'b1, 1'b1, 8'h3F, 8'h02);
        check("held", 8'(rd_valid), 8'h01);
        stall = 1'b0;
        wait_for("rdv", 1'b0, 100);
        check("rd_cnt", 8'(got.size()), 8'h02);
        check("rd0", got[0], d0);
        check("rd1", got[1], init_val(0));
        check("ptr_end", {2'b00, u_dev.ptr_q}, 8'h01);
        absent <= 1'b1;
        run_cmd(1'b0, 1'b0, 8'h00, 8'h00);
        check("nack", 8'(nack), 8'h01);
        check("released", 8'(sda_w && scl_w), 8'h01);
        stop_test();
    end
endmodule
